// file: shared/cio_pkg.sv
// Purpose: Constants and carrier types for the CMOS I/O port block
// Assumes: Ten ports packed into eight-bit lanes, APB register access
// Notes: Lane index 0..9 stands for ports 0, 2, 3, 4, 5, 6, 8, 9, C, D
`default_nettype none

package cio_pkg;

   localparam int CIO_NUM_PORTS = 10;
   localparam int CIO_LANE_W = 8;
   localparam int CIO_ADDR_W = 12;

   typedef logic [CIO_NUM_PORTS-1:0][CIO_LANE_W-1:0] cio_bank_type;

   // Implemented pins per lane, low bits first
   localparam cio_bank_type CIO_PORT_MASK = {8'h03, 8'h3f, 8'h3f, 8'h3f, 8'h0f,
                                             8'h03, 8'h3f, 8'h0f, 8'h3f, 8'h0f};

   // Lanes that carry serial functions
   localparam int CIO_LANE_P2 = 1;
   localparam int CIO_LANE_P3 = 2;
   localparam logic [7:0] CIO_P2_FSEL_MASK = 8'h3f;
   localparam logic [7:0] CIO_P3_FSEL_MASK = 8'h0f;

   // Pin positions of the serial functions inside lanes 1 and 2
   localparam int CIO_P2_TX0 = 0;
   localparam int CIO_P2_CLK0 = 1;
   localparam int CIO_P2_RX0 = 2;
   localparam int CIO_P2_TX1 = 3;
   localparam int CIO_P2_CLK1 = 4;
   localparam int CIO_P2_RX1 = 5;
   localparam int CIO_P3_TX2 = 0;
   localparam int CIO_P3_CLK2 = 1;
   localparam int CIO_P3_RX2 = 2;
   localparam int CIO_P3_CS2 = 3;

   // Register map: lane n occupies 0x10*n, function selects follow
   localparam logic [1:0] CIO_REG_DIR = 2'h0;
   localparam logic [1:0] CIO_REG_PULL = 2'h1;
   localparam logic [1:0] CIO_REG_DOUT = 2'h2;
   localparam logic [1:0] CIO_REG_DIN = 2'h3;
   localparam logic [3:0] CIO_FSEL_INDEX = 4'ha;
   localparam logic [CIO_ADDR_W-1:0] CIO_ADDR_FSEL2 = 12'h0a0;
   localparam logic [CIO_ADDR_W-1:0] CIO_ADDR_FSEL3 = 12'h0a4;

   localparam cio_bank_type CIO_BANK_RESET = '0;
   localparam logic [31:0] CIO_RDATA_RESET = 32'h0000_0000;

   // Oscillation stabilization wait in pclk cycles
   localparam logic [15:0] CIO_STAB_CYCLES_DEFAULT = 16'h4000;

   typedef enum logic [1:0] {CIO_ST_HOLD, CIO_ST_WAIT, CIO_ST_RUN} cio_rst_state_type;

   // From the serial interfaces toward the pins
   typedef struct packed {
      logic [2:0] tx;
      logic [2:0] clk_out;
      logic cs2;
   } cio_serial_drive_type;

   // From the pins toward the serial interfaces
   typedef struct packed {
      logic [2:0] rx;
      logic [2:0] clk_in;
   } cio_serial_sense_type;

endpackage

`default_nettype wire

// file: design/cio_ports.sv
// Purpose: CMOS I/O ports with serial pin multiplexing and reset pin sequencing
// Assumes: Single pclk domain, pins and reset pin are asynchronous and synchronised here
// Notes: Reset pin sequencing gates every configuration write
// Function
// RULE1: Ten ports at fixed 2/4/6 bit widths
// RULE2: Per-pin direction from direction register bit
// RULE3: Per-pin pull-up from pull-up select bit
// RULE4: Reset clears direction and pull-up bits
// RULE5: Transmit drives when output and function selected
// RULE6: Receive feeds serial when input; pull-up selectable
// RULE7: Serial clock direction follows direction bit
// RULE8: Unselected serial pins behave as ordinary port bits
// RULE9: Fixed serial mapping on ports 2 and 3
// RULE10: Reset pin low holds state; internal pull-up
// RULE11: Stabilization wait before reset processing starts
// RULE12: Input pins synchronised before software reads them
`default_nettype none

module cio_ports
   import cio_pkg::*;
#(
   parameter logic [15:0] STAB_CYCLES = CIO_STAB_CYCLES_DEFAULT
)
(
   // Clock and bus reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CIO_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset pin and core reset release
   input wire logic reset_input_n,
   output logic reset_pullup_en,
   output logic core_reset_n,
   // Port pins
   input wire cio_bank_type pin_in,
   output cio_bank_type pin_out,
   output cio_bank_type pin_oe_n,
   output cio_bank_type pin_pullup_en,
   // Serial interfaces
   input wire cio_serial_drive_type serial_drive,
   output cio_serial_sense_type serial_sense
);

   cio_bank_type port_dir;
   cio_bank_type port_pull;
   cio_bank_type port_dout;
   cio_bank_type pin_meta;
   cio_bank_type pin_sync;
   cio_bank_type fsel;
   cio_bank_type alt_val;
   logic [7:0] port2_function_select;
   logic [7:0] port3_function_select;
   logic rst_meta;
   logic rst_sync;
   cio_rst_state_type rst_state;
   logic [15:0] stab_cnt;
   logic init;
   logic acc;
   logic wr;
   logic [3:0] lane;
   logic [1:0] sel;
   logic addr_ok;
   logic [31:0] next_prdata;
   logic next_slverr;
   cio_serial_sense_type next_sense;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Two flops on every pin and on the reset pin before any use
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta <= CIO_BANK_RESET;
         pin_sync <= CIO_BANK_RESET;
      end
      else
      begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta; // [RULE12]
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= reset_input_n;
         rst_sync <= rst_meta;
      end
   end

   // Reset pin sequencing: hold, stabilization wait, then run
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_state <= CIO_ST_HOLD;
         stab_cnt <= 16'h0000;
      end
      else
      begin
         unique case (rst_state)
            CIO_ST_HOLD:
            begin
               stab_cnt <= 16'h0000;
               if (rst_sync)
                  rst_state <= CIO_ST_WAIT;
            end
            CIO_ST_WAIT:
            begin
               stab_cnt <= stab_cnt + 16'h0001;
               if (!rst_sync)
                  rst_state <= CIO_ST_HOLD; // [RULE10]
               else if (stab_cnt >= STAB_CYCLES - 16'h0001)
                  rst_state <= CIO_ST_RUN; // [RULE11]
            end
            CIO_ST_RUN:
            begin
               stab_cnt <= 16'h0000;
               if (!rst_sync)
                  rst_state <= CIO_ST_HOLD; // [RULE10]
            end
         endcase
      end
   end

   assign init = (rst_state != CIO_ST_RUN);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_reset_n <= 1'b0;
         reset_pullup_en <= 1'b1;
      end
      else
      begin
         core_reset_n <= !init; // [RULE11]
         reset_pullup_en <= 1'b1; // [RULE10]
      end
   end

   // APB decode; one wait state, read data loaded as pready rises, write at the edge that ends the pready cycle
   assign lane = paddr[7:4];
   assign sel = paddr[3:2];
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite && addr_ok && !init;

   always_comb
   begin
      addr_ok = 1'b0;
      next_prdata = CIO_RDATA_RESET;
      if (paddr[CIO_ADDR_W-1:8] == '0 && paddr[1:0] == 2'b00)
      begin
         if (lane < CIO_FSEL_INDEX)
         begin
            addr_ok = 1'b1;
            unique case (sel)
               CIO_REG_DIR: next_prdata[7:0] = port_dir[lane];
               CIO_REG_PULL: next_prdata[7:0] = port_pull[lane];
               CIO_REG_DOUT: next_prdata[7:0] = port_dout[lane];
               CIO_REG_DIN: next_prdata[7:0] = pin_sync[lane] & CIO_PORT_MASK[lane]; // [RULE12]
            endcase
         end
         else if (paddr == CIO_ADDR_FSEL2)
         begin
            addr_ok = 1'b1;
            next_prdata[7:0] = port2_function_select;
         end
         else if (paddr == CIO_ADDR_FSEL3)
         begin
            addr_ok = 1'b1;
            next_prdata[7:0] = port3_function_select;
         end
      end
      next_slverr = !addr_ok;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= CIO_RDATA_RESET;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            prdata <= pwrite ? CIO_RDATA_RESET : next_prdata;
            pslverr <= next_slverr;
         end
         else
         begin
            prdata <= CIO_RDATA_RESET;
            pslverr <= 1'b0;
         end
      end
   end

   // Configuration registers, cleared while the reset pin sequence runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_dir <= CIO_BANK_RESET;
         port_pull <= CIO_BANK_RESET;
         port_dout <= CIO_BANK_RESET;
      end
      else if (init)
      begin
         port_dir <= CIO_BANK_RESET; // [RULE4] [RULE10]
         port_pull <= CIO_BANK_RESET; // [RULE4]
         port_dout <= CIO_BANK_RESET;
      end
      else if (wr && lane < CIO_FSEL_INDEX)
      begin
         if (sel == CIO_REG_DIR)
            port_dir[lane] <= pwdata[7:0] & CIO_PORT_MASK[lane]; // [RULE1] [RULE2]
         if (sel == CIO_REG_PULL)
            port_pull[lane] <= pwdata[7:0] & CIO_PORT_MASK[lane]; // [RULE3]
         if (sel == CIO_REG_DOUT)
            port_dout[lane] <= pwdata[7:0] & CIO_PORT_MASK[lane];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port2_function_select <= 8'h00;
         port3_function_select <= 8'h00;
      end
      else if (init)
      begin
         port2_function_select <= 8'h00;
         port3_function_select <= 8'h00;
      end
      else if (wr)
      begin
         if (paddr == CIO_ADDR_FSEL2)
            port2_function_select <= pwdata[7:0] & CIO_P2_FSEL_MASK;
         if (paddr == CIO_ADDR_FSEL3)
            port3_function_select <= pwdata[7:0] & CIO_P3_FSEL_MASK;
      end
   end

   // Serial values per pin; receive pins and lanes other than 1 and 2 stay zero
   always_comb
   begin
      fsel = CIO_BANK_RESET;
      alt_val = CIO_BANK_RESET;
      fsel[CIO_LANE_P2] = port2_function_select;
      fsel[CIO_LANE_P3] = port3_function_select;
      alt_val[CIO_LANE_P2][CIO_P2_TX0] = serial_drive.tx[0]; // [RULE9]
      alt_val[CIO_LANE_P2][CIO_P2_CLK0] = serial_drive.clk_out[0];
      alt_val[CIO_LANE_P2][CIO_P2_TX1] = serial_drive.tx[1];
      alt_val[CIO_LANE_P2][CIO_P2_CLK1] = serial_drive.clk_out[1];
      alt_val[CIO_LANE_P3][CIO_P3_TX2] = serial_drive.tx[2];
      alt_val[CIO_LANE_P3][CIO_P3_CLK2] = serial_drive.clk_out[2];
      alt_val[CIO_LANE_P3][CIO_P3_CS2] = serial_drive.cs2;
   end

   // Pin drivers registered so every pin output comes from a flop
   for (genvar p = 0; p < CIO_NUM_PORTS; p++)
   begin : g_lane
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            pin_out[p] <= 8'h00;
            pin_oe_n[p] <= 8'hff;
            pin_pullup_en[p] <= 8'h00;
         end
         else
         begin
            pin_out[p] <= ((fsel[p] & alt_val[p]) | (~fsel[p] & port_dout[p])) & CIO_PORT_MASK[p]; // [RULE5] [RULE8]
            pin_oe_n[p] <= ~(port_dir[p] & CIO_PORT_MASK[p]); // [RULE2] [RULE7]
            pin_pullup_en[p] <= port_pull[p] & CIO_PORT_MASK[p]; // [RULE3] [RULE6]
         end
      end
   end

   // Receive and clock feeds; idle high when the pin is not handed over
   always_comb
   begin
      next_sense.rx[0] = (fsel[CIO_LANE_P2][CIO_P2_RX0] && !port_dir[CIO_LANE_P2][CIO_P2_RX0]) ?
                         pin_sync[CIO_LANE_P2][CIO_P2_RX0] : 1'b1; // [RULE6]
      next_sense.rx[1] = (fsel[CIO_LANE_P2][CIO_P2_RX1] && !port_dir[CIO_LANE_P2][CIO_P2_RX1]) ?
                         pin_sync[CIO_LANE_P2][CIO_P2_RX1] : 1'b1;
      next_sense.rx[2] = (fsel[CIO_LANE_P3][CIO_P3_RX2] && !port_dir[CIO_LANE_P3][CIO_P3_RX2]) ?
                         pin_sync[CIO_LANE_P3][CIO_P3_RX2] : 1'b1;
      next_sense.clk_in[0] = (fsel[CIO_LANE_P2][CIO_P2_CLK0] && !port_dir[CIO_LANE_P2][CIO_P2_CLK0]) ?
                             pin_sync[CIO_LANE_P2][CIO_P2_CLK0] : 1'b1; // [RULE7]
      next_sense.clk_in[1] = (fsel[CIO_LANE_P2][CIO_P2_CLK1] && !port_dir[CIO_LANE_P2][CIO_P2_CLK1]) ?
                             pin_sync[CIO_LANE_P2][CIO_P2_CLK1] : 1'b1;
      next_sense.clk_in[2] = (fsel[CIO_LANE_P3][CIO_P3_CLK2] && !port_dir[CIO_LANE_P3][CIO_P3_CLK2]) ?
                             pin_sync[CIO_LANE_P3][CIO_P3_CLK2] : 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         serial_sense <= '1;
      else
         serial_sense <= next_sense;
   end

   // Checks
   sequence s_release;
      rst_state == CIO_ST_HOLD ##1 rst_state == CIO_ST_WAIT;
   endsequence

   property p_stab_wait;
      s_release |-> !core_reset_n [*4];
   endproperty
   a_stab_wait: assert property (p_stab_wait) else $error("core reset released too early"); // [RULE11]

   property p_hold_low;
      !rst_sync |=> ##1 !core_reset_n;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("core reset released while reset pin low"); // [RULE10]

   property p_init_clear;
      init |=> port_dir == CIO_BANK_RESET && port_pull == CIO_BANK_RESET;
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("config not cleared in init"); // [RULE4]

   property p_dir_write;
      wr && lane == 4'h0 && sel == CIO_REG_DIR |=> ##1 pin_oe_n[0][3:0] == ~$past(pwdata[3:0], 2);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write not seen on pin enable"); // [RULE2]

   property p_width;
      1 |-> (pin_oe_n[9][7:2] == 6'h3f) && (pin_out[0][7:4] == 4'h0) && (pin_pullup_en[1][7:6] == 2'h0);
   endproperty
   a_width: assert property (p_width) else $error("unimplemented pin bit active"); // [RULE1]

   property p_pull;
      1 |=> pin_pullup_en[3] == ($past(port_pull[3]) & CIO_PORT_MASK[3]);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up enable mismatch"); // [RULE3]

   property p_tx_mux;
      port2_function_select[0] && port_dir[1][0] |=> pin_out[1][0] == $past(serial_drive.tx[0]) && !pin_oe_n[1][0];
   endproperty
   a_tx_mux: assert property (p_tx_mux) else $error("serial transmit not on pin"); // [RULE5] [RULE9]

   property p_plain;
      !port3_function_select[0] |=> pin_out[2][0] == $past(port_dout[2][0]);
   endproperty
   a_plain: assert property (p_plain) else $error("plain port bit overridden"); // [RULE8]

   property p_rx_feed;
      port3_function_select[2] && !port_dir[2][2] |=> serial_sense.rx[2] == $past(pin_sync[2][2]);
   endproperty
   a_rx_feed: assert property (p_rx_feed) else $error("receive pin not fed to serial"); // [RULE6]

   property p_clk_in;
      port2_function_select[4] && !port_dir[1][4] |=> serial_sense.clk_in[1] == $past(pin_sync[1][4]);
   endproperty
   a_clk_in: assert property (p_clk_in) else $error("serial clock input not fed"); // [RULE7]

   property p_sync;
      1 |-> ##2 pin_sync == $past(pin_meta);
   endproperty
   a_sync: assert property (p_sync) else $error("input synchroniser broken"); // [RULE12]

   property p_one_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("APB answer timing wrong");

endmodule

`default_nettype wire

// file: verification/cio_board_model.sv
// Purpose: Board and pin wiring around the I/O ports, including the reset pin
// Assumes: Bench sets the external pin levels and holds the reset pin low on command
// Notes: A floating pin without pull-up shows the inverse of its last level
`default_nettype none

module cio_board_model
   import cio_pkg::*;
(
   // Design side
   input wire logic pclk,
   input wire cio_bank_type pin_out,
   input wire cio_bank_type pin_oe_n,
   input wire cio_bank_type pin_pullup_en,
   input wire logic reset_pullup_en,
   // Bench commands
   input wire logic rst_low,
   input wire cio_bank_type ext_val,
   input wire cio_bank_type ext_en,
   // Wire levels seen by the design
   output cio_bank_type pin_in,
   output logic reset_input_n
);
   timeunit 1ns;
   timeprecision 1ps;
   cio_bank_type last;
   always_ff @(posedge pclk)
   begin
      last <= pin_in;
   end
   always_comb
   begin
      for (int i = 0; i < CIO_NUM_PORTS; i++)
      begin
         for (int b = 0; b < CIO_LANE_W; b++)
         begin
            // A driving design wins over the board so contention never hides a fault
            if (pin_oe_n[i][b] === 1'b0)
               pin_in[i][b] = pin_out[i][b];
            else if (ext_en[i][b] === 1'b1)
               pin_in[i][b] = ext_val[i][b];
            else if (pin_pullup_en[i][b] === 1'b1)
               pin_in[i][b] = 1'b1;
            else
               pin_in[i][b] = ~last[i][b];
         end
      end
   end
   // Released reset pin rises only through the internal pull-up
   assign reset_input_n = rst_low ? 1'b0 : reset_pullup_en;
endmodule

`default_nettype wire

// file: verification/cio_ports_tb_top.sv
// Purpose: Self-checking bench for the I/O ports and serial pin multiplexing
// Assumes: APB master here, board model on the pins, short stabilization count
// Notes: Table rows cover every lane; serial and reset pin cases follow
`default_nettype none

module cio_ports_tb_top;
   import cio_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STAB = 8;
   typedef struct packed {
      logic [3:0] lane;
      logic [7:0] dir;
      logic [7:0] pull;
      logic [7:0] dout;
      logic [7:0] ext;
   } cio_row_type;
   localparam cio_row_type ROWS [10] = '{'{4'h0, 8'h05, 8'h0a, 8'hff, 8'hff}, '{4'h1, 8'h3f, 8'h00, 8'h2a, 8'h00},
      '{4'h2, 8'h00, 8'h0f, 8'h00, 8'h0a}, '{4'h3, 8'h2a, 8'h15, 8'h3f, 8'h15}, '{4'h4, 8'h03, 8'hff, 8'h01, 8'h00},
      '{4'h5, 8'h0c, 8'h03, 8'hff, 8'h03}, '{4'h6, 8'hff, 8'h00, 8'h15, 8'h00}, '{4'h7, 8'h01, 8'h3e, 8'h01, 8'h3e},
      '{4'h8, 8'h20, 8'h1f, 8'h20, 8'h1f}, '{4'h9, 8'h02, 8'h01, 8'h00, 8'h01}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_low, reset_input_n, reset_pullup_en, core_reset_n;
   logic [CIO_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic er;
   cio_bank_type pin_in, pin_out, pin_oe_n, pin_pullup_en, ext_val, ext_en;
   cio_serial_drive_type serial_drive;
   cio_serial_sense_type serial_sense;
   int num_errors, n_checks, cyc, waited;
   cio_row_type r;
   logic [11:0] base;
   logic [7:0] m;

   cio_ports #(.STAB_CYCLES(16'h0008)) i_cio_ports (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_input_n(reset_input_n), .reset_pullup_en(reset_pullup_en),
      .core_reset_n(core_reset_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .serial_drive(serial_drive), .serial_sense(serial_sense));
   cio_board_model i_cio_board_model (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .reset_pullup_en(reset_pullup_en), .rst_low(rst_low),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in), .reset_input_n(reset_input_n));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task finish_test;
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      // Whole run needs well under a thousand cycles
      if (cyc == 5000)
      begin
         num_errors++;
         finish_test;
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Count edges from reset pin release until reset processing may start
   task wait_core;
      waited = 0;
      while (core_reset_n !== 1'b1 && waited < 100)
      begin
         @(posedge pclk);
         waited++;
      end
      chk(waited >= STAB && waited <= STAB + 6, 1);
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      rst_low = 1'b1;
      ext_val = '0;
      ext_en = '1;
      serial_drive = '0;
      repeat (20) @(posedge pclk);
      chk(&pin_oe_n, 1);
      chk(|pin_pullup_en, 0);
      chk({core_reset_n, reset_pullup_en, &serial_sense}, 3'b011);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      rst_low <= 1'b0;
      wait_core;
      for (int i = 0; i < 10; i++)
      begin
         r = ROWS[i];
         base = {4'h0, r.lane, 4'h0};
         m = CIO_PORT_MASK[r.lane];
         apb(1'b0, base, 0);
         chk(rd, 0);
         apb(1'b0, base + 12'h004, 0);
         chk(rd, 0);
         ext_val[r.lane] <= r.ext;
         apb(1'b1, base + 12'h008, {24'h0, r.dout});
         apb(1'b1, base, {24'h0, r.dir});
         apb(1'b1, base + 12'h004, {24'h0, r.pull});
         repeat (4) @(posedge pclk);
         chk(pin_oe_n[r.lane], 8'(~(r.dir & m)));
         chk(pin_pullup_en[r.lane], r.pull & m);
         chk(pin_out[r.lane] & r.dir & m, r.dout & r.dir & m);
         apb(1'b0, base, 0);
         chk(rd, r.dir & m);
         chk(er, 0);
         apb(1'b0, base + 12'h00c, 0);
         chk(rd, ((r.dout & r.dir) | (r.ext & ~r.dir)) & m);
      end
      apb(1'b0, 12'h0a8, 0);
      chk(er, 1);
      apb(1'b0, 12'h002, 0);
      chk(er, 1);
      // Serial lanes: plain port first, then handed over
      apb(1'b1, 12'h018, 0);
      apb(1'b1, 12'h010, 32'h0000_001b);
      apb(1'b1, 12'h020, 32'h0000_0009);
      ext_val[1] <= 8'h20;
      ext_val[2] <= 8'h00;
      serial_drive <= '{tx: 3'b011, clk_out: 3'b010, cs2: 1'b1};
      repeat (5) @(posedge pclk);
      chk(pin_out[1] & 8'h1b, 0);
      chk(serial_sense.rx, 3'b111);
      apb(1'b1, CIO_ADDR_FSEL2, 32'h0000_003f);
      apb(1'b1, CIO_ADDR_FSEL3, 32'h0000_000f);
      apb(1'b1, 12'h014, 32'h0000_0024);
      apb(1'b0, CIO_ADDR_FSEL2, 0);
      chk(rd, 32'h0000_003f);
      repeat (5) @(posedge pclk);
      chk(pin_out[1] & 8'h1b, 32'h0000_0019);
      chk(pin_out[2] & 8'h09, 32'h0000_0008);
      chk(serial_sense.rx, 3'b010);
      chk(serial_sense.clk_in[2], 0);
      chk(pin_pullup_en[1], 32'h0000_0024);
      serial_drive <= '0;
      repeat (3) @(posedge pclk);
      chk(pin_out[1] & 8'h1b, 0);
      // Reset pin pulled low in mid-run clears configuration and blocks writes
      rst_low <= 1'b1;
      // Two sync flops, hold entry, clear, then the registered pin enables
      repeat (7) @(posedge pclk);
      chk({&pin_oe_n, |pin_pullup_en, core_reset_n}, 3'b100);
      apb(1'b1, 12'h000, 32'h0000_000f);
      apb(1'b0, 12'h000, 0);
      chk(rd, 0);
      rst_low <= 1'b0;
      wait_core;
      finish_test;
   end
endmodule

`default_nettype wire
